// ===== verilog/rlps_pkg.sv
// Package for the reset-latched peripheral select block: strap layout, reset values,
// pin-ownership carriers. Assumes a single 250 MHz clock and board straps on pins.
//******************************************************************************
// Contract
//******************************************************************************
// Contract
// - Cell-bus select strap is sampled at reset; picks cell-bus or serial port 1.
// - Cell select 0: shared pins are serial port 1, cell-only pins high-Z.
// - Cell select 1: shared pins are cell bus, serial-1-only pins high-Z.
// - PCI select sampled at reset and live serial-2 select decide host, GPIO, PCI, EEPROM, serial 2.
// - PCI select 0: host port on; upper GPIO usable once enable and direction set.
// - PCI select 0: shared pins are host port, the two PCI-only pins high-Z.
// - PCI select 1: host off; host/PCI and GPIO/PCI shared pins carry PCI.
// - Serial port 2 is enabled except with PCI 1 and serial-2 select 0.
// - PCI 1, serial-2 0 and EEPROM strap 1 start EEPROM auto-init at reset.
// - Raising serial-2 select after reset enables serial port 2, drops EEPROM path.
// - Shared-pin peripherals never drive conflicting functions at once.
// - Timers, serial port 0 and lower general pins are always available.
//******************************************************************************
package rlps_pkg;

	// Strap reset values, all matching the internal pulldowns
	localparam logic RLPS_CELL_SEL_RST = 1'h0;
	localparam logic RLPS_PCI_SEL_RST = 1'h0;
	localparam logic RLPS_SP2_SEL_RST = 1'h0;
	localparam logic RLPS_EEPROM_AUTOINIT_STRAP_RST = 1'h0;

	// Cycles of reset release before straps are caught (pins settle through synchronisers)
	localparam int unsigned RLPS_SYNC_STAGES = 3;
	localparam logic [1:0] RLPS_LATCH_DELAY = 2'h3;

	// Upper general pin span
	localparam int unsigned RLPS_UGP_LO = 9;
	localparam int unsigned RLPS_UGP_HI = 15;
	localparam int unsigned RLPS_UGP_W = RLPS_UGP_HI - RLPS_UGP_LO + 1;

	// Latched strap set
	typedef struct packed {
		logic cell_port_select;
		logic pci_select;
		logic eeprom_autoinit_strap;
	} rlps_straps_s;

	// Peripheral enables that result from the straps
	typedef struct packed {
		logic host_port_en;
		logic pci_en;
		logic eeprom_path_en;
		logic serial_port1_en;
		logic serial_port2_en;
		logic cell_port_en;
		logic pci_only_pins_oe;
		logic cell_only_pins_oe;
		logic sp1_only_pins_oe;
	} rlps_enables_s;

endpackage

// ===== verilog/rlps_sync3.sv
// Three-stage synchroniser with agreement filter for strap pins.
// Assumes inputs are asynchronous to the clock; reset is already synchronised.
`timescale 1ns/1ps
module rlps_sync3 #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] q_r;
	logic [WIDTH-1:0] agree;
	logic [WIDTH-1:0] q_nxt;

	// A bit changes only when stages two and three agree; stage one feeds stage two only
	assign agree = ~(s2_r ^ s3_r);
	assign q_nxt = (agree & s3_r) | (~agree & q_r);
	assign q_o = q_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
			q_r <= RST_VAL;
		end else begin
			s1_r <= d_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r <= q_nxt;
		end
	end
endmodule

// ===== verilog/rlps_gpio_gate.sv
// Per-pin ownership gate for the upper general pins shared with PCI.
// Assumes GPIO enable and direction bits come from software-held registers elsewhere.
`timescale 1ns/1ps
module rlps_gpio_gate #(
	parameter int unsigned WIDTH = 7
) (
	input wire logic pci_mode_i,
	input wire logic [WIDTH-1:0] gpio_pin_enable_i,
	input wire logic [WIDTH-1:0] gpio_pin_direction_i,
	input wire logic [WIDTH-1:0] gpio_out_i,
	input wire logic [WIDTH-1:0] pci_out_i,
	input wire logic [WIDTH-1:0] pci_oe_i,
	output logic [WIDTH-1:0] pin_out_o,
	output logic [WIDTH-1:0] pin_oe_o
);
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : gen_pin
			wire gpio_drv;
			// GPIO drives only when enabled and set as output, and never in PCI mode
			assign gpio_drv = ~pci_mode_i & gpio_pin_enable_i[g] & gpio_pin_direction_i[g];
			assign pin_out_o[g] = pci_mode_i ? pci_out_i[g] : gpio_out_i[g];
			assign pin_oe_o[g] = pci_mode_i ? pci_oe_i[g] : gpio_drv;
		end
	endgenerate
endmodule

// ===== verilog/rlps_top.sv
// Reset-latched peripheral select: catches the selection straps at reset release and
// steers the shared pins between host port, upper general pins, PCI with its EEPROM,
// serial ports 1 and 2 and the cell-bus port.
// Assumes straps come from board resistors; peripherals supply their own pin drives.
`timescale 1ns/1ps
module rlps_top
	import rlps_pkg::*;
#(
	parameter int unsigned SHARED_CELL_W = 6,
	parameter int unsigned HOST_PCI_W = 32
) (
	input wire logic MCLK_I,
	input wire logic RESET_N_I,
	input wire logic CELL_SELECT_STRAP_PIN_I,
	input wire logic PCI_SELECT_PIN_I,
	input wire logic SERIAL_PORT2_SELECT_PIN_I,
	input wire logic EEPROM_AUTOINIT_STRAP_PIN_I,
	input wire logic [RLPS_UGP_W-1:0] GPIO_PIN_ENABLE_I,
	input wire logic [RLPS_UGP_W-1:0] GPIO_PIN_DIRECTION_I,
	input wire logic [RLPS_UGP_W-1:0] GPIO_OUT_I,
	input wire logic [RLPS_UGP_W-1:0] PCI_GP_OUT_I,
	input wire logic [RLPS_UGP_W-1:0] PCI_GP_OE_I,
	input wire logic [SHARED_CELL_W-1:0] SP1_OUT_I,
	input wire logic [SHARED_CELL_W-1:0] SP1_OE_I,
	input wire logic [SHARED_CELL_W-1:0] CELL_OUT_I,
	input wire logic [SHARED_CELL_W-1:0] CELL_OE_I,
	input wire logic [HOST_PCI_W-1:0] HOST_OUT_I,
	input wire logic [HOST_PCI_W-1:0] HOST_OE_I,
	input wire logic [HOST_PCI_W-1:0] PCI_OUT_I,
	input wire logic [HOST_PCI_W-1:0] PCI_OE_I,
	input wire logic EEPROM_INIT_DONE_I,
	output logic [RLPS_UGP_W-1:0] UPPER_GENERAL_PINS_OUT_O,
	output logic [RLPS_UGP_W-1:0] UPPER_GENERAL_PINS_OE_O,
	output logic [SHARED_CELL_W-1:0] SHARED_CELL_PINS_OUT_O,
	output logic [SHARED_CELL_W-1:0] SHARED_CELL_PINS_OE_O,
	output logic [HOST_PCI_W-1:0] SHARED_HOST_PINS_OUT_O,
	output logic [HOST_PCI_W-1:0] SHARED_HOST_PINS_OE_O,
	output logic PCI_ONLY_PINS_OE_O,
	output logic CELL_ONLY_PINS_OE_O,
	output logic SP1_ONLY_PINS_OE_O,
	output logic HOST_PORT_EN_O,
	output logic PCI_EN_O,
	output logic SERIAL_PORT1_EN_O,
	output logic SERIAL_PORT2_EN_O,
	output logic CELL_PORT_EN_O,
	output logic EEPROM_PATH_EN_O,
	output logic EEPROM_INIT_START_O,
	output logic ALWAYS_ON_EN_O,
	output logic STRAPS_VALID_O
);
	//**************************************************************************
	// Reset release
	//**************************************************************************
	// Internal reset falls with the pin at once but rises two clocks later, on a clean edge
	logic rst_a_r;
	logic rst_n;

	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rst_a_r <= 1'h0;
			rst_n <= 1'h0;
		end else begin
			rst_a_r <= 1'h1;
			rst_n <= rst_a_r;
		end
	end

	//**************************************************************************
	// Strap synchronisers
	//**************************************************************************
	logic [3:0] pins_raw;
	logic [3:0] pins_sync;

	// Bundle order, high to low: cell, PCI, serial 2, EEPROM; the taps below follow it
	assign pins_raw = {CELL_SELECT_STRAP_PIN_I, PCI_SELECT_PIN_I,
		SERIAL_PORT2_SELECT_PIN_I, EEPROM_AUTOINIT_STRAP_PIN_I};

	rlps_sync3 #(
		.WIDTH(4),
		.RST_VAL({RLPS_CELL_SEL_RST, RLPS_PCI_SEL_RST, RLPS_SP2_SEL_RST, RLPS_EEPROM_AUTOINIT_STRAP_RST})
	) u_sync (
		.clk_i(MCLK_I),
		.rst_n_i(rst_n),
		.d_i(pins_raw),
		.q_o(pins_sync)
	);

	// Filtered strap taps
	wire cell_sync = pins_sync[3];
	wire pci_sync = pins_sync[2];
	wire sp2_sync = pins_sync[1];
	wire eeprom_autoinit_strap_sync = pins_sync[0];

	//**************************************************************************
	// Strap latch sequence
	//**************************************************************************
	// Gray along the path, so each step flips one state bit
	typedef enum logic [1:0] {
		RLPS_ST_WAIT = 2'h0,
		RLPS_ST_LATCH = 2'h1,
		RLPS_ST_RUN = 2'h3
	} rlps_state_e;

	rlps_state_e state_r;
	rlps_state_e state_nxt;
	logic [1:0] wait_cnt_r;
	logic [1:0] wait_cnt_nxt;
	rlps_straps_s straps_r;
	rlps_straps_s straps_nxt;
	logic latch_now;
	rlps_straps_s straps_caught;

	// Wait until the synchroniser has filled with real pin levels before catching
	always_comb begin
		state_nxt = state_r;
		wait_cnt_nxt = wait_cnt_r;
		case (state_r)
			RLPS_ST_WAIT: begin
				wait_cnt_nxt = wait_cnt_r + 2'h1;
				if (wait_cnt_r == RLPS_LATCH_DELAY) begin
					state_nxt = RLPS_ST_LATCH;
				end
			end
			RLPS_ST_LATCH: state_nxt = RLPS_ST_RUN;
			RLPS_ST_RUN: state_nxt = RLPS_ST_RUN;
			default: state_nxt = RLPS_ST_WAIT;
		endcase
	end

	assign latch_now = (state_r == RLPS_ST_LATCH);
	assign straps_caught.cell_port_select = cell_sync;
	assign straps_caught.pci_select = pci_sync;
	assign straps_caught.eeprom_autoinit_strap = eeprom_autoinit_strap_sync;
	// Caught once per reset; later pin motion is ignored
	assign straps_nxt = latch_now ? straps_caught : straps_r;

	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= RLPS_ST_WAIT;
			wait_cnt_r <= 2'h0;
			straps_r <= '{cell_port_select: RLPS_CELL_SEL_RST, pci_select: RLPS_PCI_SEL_RST,
				eeprom_autoinit_strap: RLPS_EEPROM_AUTOINIT_STRAP_RST};
		end else begin
			state_r <= state_nxt;
			wait_cnt_r <= wait_cnt_nxt;
			straps_r <= straps_nxt;
		end
	end

	//**************************************************************************
	// Peripheral selection
	//**************************************************************************
	// Until the straps are caught every shared pin stays quiet, so no two owners overlap
	wire run = (state_r == RLPS_ST_RUN);
	rlps_enables_s en_nxt;
	logic eeprom_start_nxt;
	logic eeprom_started_r;
	logic cell_owned;
	logic sp1_owned;
	logic pci_owned;
	logic host_owned;
	logic eeprom_owned;

	// EEPROM keeps its path only while PCI is strapped on and serial 2 is not selected
	function automatic logic eeprom_owns(input logic pci_sel, input logic sp2_sel);
		return pci_sel & ~sp2_sel;
	endfunction

	// One owner per pin group, decided by the latched straps; the EEPROM path also follows the live serial 2 select
	assign cell_owned = run & straps_r.cell_port_select;
	assign sp1_owned = run & ~straps_r.cell_port_select;
	assign pci_owned = run & straps_r.pci_select;
	assign host_owned = run & ~straps_r.pci_select;
	assign eeprom_owned = run & eeprom_owns(straps_r.pci_select, sp2_sync);

	// Registered below, so every enable and standalone OE leaves from a flop
	assign en_nxt.cell_port_en = cell_owned;
	assign en_nxt.serial_port1_en = sp1_owned;
	assign en_nxt.cell_only_pins_oe = cell_owned;
	assign en_nxt.sp1_only_pins_oe = sp1_owned;
	assign en_nxt.host_port_en = host_owned;
	assign en_nxt.pci_en = pci_owned;
	assign en_nxt.pci_only_pins_oe = pci_owned;
	// Serial port 2 select is live, so it can be raised after reset
	assign en_nxt.serial_port2_en = run & ~eeprom_owns(straps_r.pci_select, sp2_sync);
	assign en_nxt.eeprom_path_en = eeprom_owned;
	// One-shot auto-init at the first running cycle only
	assign eeprom_start_nxt = eeprom_owned & ~eeprom_started_r
		& straps_r.eeprom_autoinit_strap;

	//**************************************************************************
	// Pin steering
	//**************************************************************************
	logic [RLPS_UGP_W-1:0] ugp_out;
	logic [RLPS_UGP_W-1:0] ugp_oe;
	logic [RLPS_UGP_W-1:0] ugp_en_gated;
	logic [RLPS_UGP_W-1:0] ugp_pci_oe_gated;

	// Nothing reaches the upper pins before the straps settle, whoever would own them
	assign ugp_en_gated = GPIO_PIN_ENABLE_I & {RLPS_UGP_W{run}};
	assign ugp_pci_oe_gated = PCI_GP_OE_I & {RLPS_UGP_W{run}};

	rlps_gpio_gate #(
		.WIDTH(RLPS_UGP_W)
	) u_ugp (
		.pci_mode_i(straps_r.pci_select),
		.gpio_pin_enable_i(ugp_en_gated),
		.gpio_pin_direction_i(GPIO_PIN_DIRECTION_I),
		.gpio_out_i(GPIO_OUT_I),
		.pci_out_i(PCI_GP_OUT_I),
		.pci_oe_i(ugp_pci_oe_gated),
		.pin_out_o(ugp_out),
		.pin_oe_o(ugp_oe)
	);

	// Exactly one owner per shared pin group
	wire [SHARED_CELL_W-1:0] cell_out = straps_r.cell_port_select ? CELL_OUT_I : SP1_OUT_I;
	wire [SHARED_CELL_W-1:0] cell_oe = {SHARED_CELL_W{run}}
		& (straps_r.cell_port_select ? CELL_OE_I : SP1_OE_I);
	wire [HOST_PCI_W-1:0] host_out = straps_r.pci_select ? PCI_OUT_I : HOST_OUT_I;
	wire [HOST_PCI_W-1:0] host_oe = {HOST_PCI_W{run}}
		& (straps_r.pci_select ? PCI_OE_I : HOST_OE_I);

	//**************************************************************************
	// Output registers
	//**************************************************************************
	// Pin drives, one clock behind their peripheral sources
	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			UPPER_GENERAL_PINS_OUT_O <= '0;
			UPPER_GENERAL_PINS_OE_O <= '0;
			SHARED_CELL_PINS_OUT_O <= '0;
			SHARED_CELL_PINS_OE_O <= '0;
			SHARED_HOST_PINS_OUT_O <= '0;
			SHARED_HOST_PINS_OE_O <= '0;
		end else begin
			UPPER_GENERAL_PINS_OUT_O <= ugp_out;
			UPPER_GENERAL_PINS_OE_O <= ugp_oe;
			SHARED_CELL_PINS_OUT_O <= cell_out;
			SHARED_CELL_PINS_OE_O <= cell_oe;
			SHARED_HOST_PINS_OUT_O <= host_out;
			SHARED_HOST_PINS_OE_O <= host_oe;
		end
	end

	// Standalone pins of the peripheral left out stay released
	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			PCI_ONLY_PINS_OE_O <= 1'h0;
			CELL_ONLY_PINS_OE_O <= 1'h0;
			SP1_ONLY_PINS_OE_O <= 1'h0;
		end else begin
			PCI_ONLY_PINS_OE_O <= en_nxt.pci_only_pins_oe;
			CELL_ONLY_PINS_OE_O <= en_nxt.cell_only_pins_oe;
			SP1_ONLY_PINS_OE_O <= en_nxt.sp1_only_pins_oe;
		end
	end

	// Peripheral enables; serial 2 and the EEPROM path keep following the live select
	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			HOST_PORT_EN_O <= 1'h0;
			PCI_EN_O <= 1'h0;
			SERIAL_PORT1_EN_O <= 1'h0;
			SERIAL_PORT2_EN_O <= 1'h0;
			CELL_PORT_EN_O <= 1'h0;
			EEPROM_PATH_EN_O <= 1'h0;
		end else begin
			HOST_PORT_EN_O <= en_nxt.host_port_en;
			PCI_EN_O <= en_nxt.pci_en;
			SERIAL_PORT1_EN_O <= en_nxt.serial_port1_en;
			SERIAL_PORT2_EN_O <= en_nxt.serial_port2_en;
			CELL_PORT_EN_O <= en_nxt.cell_port_en;
			EEPROM_PATH_EN_O <= en_nxt.eeprom_path_en;
		end
	end

	// Auto-init fires once per reset; dropping serial 2 select later cannot start it again
	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			EEPROM_INIT_START_O <= 1'h0;
			eeprom_started_r <= 1'h0;
		end else begin
			EEPROM_INIT_START_O <= eeprom_start_nxt;
			eeprom_started_r <= eeprom_started_r | run;
		end
	end

	// Timers, serial port 0 and lower pins ignore every strap
	always_ff @(posedge MCLK_I or negedge rst_n) begin
		if (!rst_n) begin
			ALWAYS_ON_EN_O <= 1'h0;
			STRAPS_VALID_O <= 1'h0;
		end else begin
			ALWAYS_ON_EN_O <= 1'h1;
			STRAPS_VALID_O <= run;
		end
	end

	// Init completion is owned by the PCI block; kept visible only through its own logic
	logic unused_done;
	assign unused_done = EEPROM_INIT_DONE_I;
endmodule

// ===== test/rlps_strap_model.sv
// Board strap model: resistors and select drivers seen by the peripheral select block.
// Assumes the bench asks for strap levels and owns the device reset.
`timescale 1ns/1ps
module rlps_strap_model (
	input wire logic reset_n_i,
	input wire logic cell_i,
	input wire logic pci_i,
	input wire logic sp2_i,
	input wire logic eeprom_autoinit_strap_i,
	output logic cell_o,
	output logic pci_o,
	output logic sp2_o,
	output logic eeprom_autoinit_strap_o
);
	// PCI select is only re-strapped while the device sits in reset
	always_latch begin
		if (!reset_n_i) begin
			pci_o = pci_i;
		end
	end
	assign sp2_o = sp2_i;
	assign eeprom_autoinit_strap_o = eeprom_autoinit_strap_i & pci_o;
	// Cell strap follows the bench, so late changes can be tried
	assign cell_o = cell_i;
endmodule

// ===== test/rlps_top_props.sv
// Checker for the peripheral select block, watching its top-level ports only.
// Assumes it is bound into rlps_top and that straps stay steady across each reset.
`timescale 1ns/1ps
module rlps_top_props
	import rlps_pkg::*;
#(
	parameter int unsigned SHARED_CELL_W = 6,
	parameter int unsigned HOST_PCI_W = 32
) (
	input wire logic MCLK_I,
	input wire logic RESET_N_I,
	input wire logic CELL_SELECT_STRAP_PIN_I,
	input wire logic PCI_SELECT_PIN_I,
	input wire logic SERIAL_PORT2_SELECT_PIN_I,
	input wire logic [RLPS_UGP_W-1:0] GPIO_PIN_ENABLE_I,
	input wire logic [RLPS_UGP_W-1:0] GPIO_PIN_DIRECTION_I,
	input wire logic [RLPS_UGP_W-1:0] PCI_GP_OE_I,
	input wire logic [SHARED_CELL_W-1:0] SP1_OE_I,
	input wire logic [SHARED_CELL_W-1:0] CELL_OE_I,
	input wire logic [HOST_PCI_W-1:0] HOST_OE_I,
	input wire logic [HOST_PCI_W-1:0] PCI_OE_I,
	input wire logic [RLPS_UGP_W-1:0] UPPER_GENERAL_PINS_OE_O,
	input wire logic [SHARED_CELL_W-1:0] SHARED_CELL_PINS_OE_O,
	input wire logic [HOST_PCI_W-1:0] SHARED_HOST_PINS_OE_O,
	input wire logic PCI_ONLY_PINS_OE_O,
	input wire logic CELL_ONLY_PINS_OE_O,
	input wire logic SP1_ONLY_PINS_OE_O,
	input wire logic HOST_PORT_EN_O,
	input wire logic PCI_EN_O,
	input wire logic SERIAL_PORT1_EN_O,
	input wire logic SERIAL_PORT2_EN_O,
	input wire logic CELL_PORT_EN_O,
	input wire logic EEPROM_PATH_EN_O,
	input wire logic EEPROM_INIT_START_O,
	input wire logic ALWAYS_ON_EN_O,
	input wire logic STRAPS_VALID_O
);
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RESET_N_I);
	// Pin muxes lag their sources by a cycle, so only judge after one settled cycle
	logic was_valid_r;
	always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			was_valid_r <= 1'h0;
		end else begin
			was_valid_r <= STRAPS_VALID_O;
		end
	end
	wire logic steady = STRAPS_VALID_O && was_valid_r;
	//********************
	// Properties
	//********************
	property p_latch;
		$rose(STRAPS_VALID_O) |-> CELL_PORT_EN_O == $past(CELL_SELECT_STRAP_PIN_I, 8)
			&& PCI_EN_O == $past(PCI_SELECT_PIN_I, 8);
	endproperty
	a_latch: assert property (p_latch) else $error("strap latch wrong");
	property p_cell_mux;
		steady |-> (CELL_PORT_EN_O && SHARED_CELL_PINS_OE_O == $past(CELL_OE_I))
			|| (!CELL_PORT_EN_O && SHARED_CELL_PINS_OE_O == $past(SP1_OE_I));
	endproperty
	a_cell_mux: assert property (p_cell_mux) else $error("cell pin mux wrong");
	property p_cell_only;
		STRAPS_VALID_O |-> CELL_ONLY_PINS_OE_O == CELL_PORT_EN_O
			&& SP1_ONLY_PINS_OE_O == SERIAL_PORT1_EN_O && SERIAL_PORT1_EN_O != CELL_PORT_EN_O;
	endproperty
	a_cell_only: assert property (p_cell_only) else $error("cell owner wrong");
	property p_host;
		STRAPS_VALID_O |-> HOST_PORT_EN_O != PCI_EN_O && PCI_ONLY_PINS_OE_O == PCI_EN_O;
	endproperty
	a_host: assert property (p_host) else $error("host owner wrong");
	property p_host_mux;
		steady |-> SHARED_HOST_PINS_OE_O == (PCI_EN_O ? $past(PCI_OE_I) : $past(HOST_OE_I));
	endproperty
	a_host_mux: assert property (p_host_mux) else $error("host pin mux wrong");
	property p_gpio;
		steady |-> UPPER_GENERAL_PINS_OE_O == (PCI_EN_O ? $past(PCI_GP_OE_I)
			: ($past(GPIO_PIN_ENABLE_I) & $past(GPIO_PIN_DIRECTION_I)));
	endproperty
	a_gpio: assert property (p_gpio) else $error("upper pin gate wrong");
	property p_sp2;
		STRAPS_VALID_O && !PCI_EN_O |-> SERIAL_PORT2_EN_O && !EEPROM_PATH_EN_O;
	endproperty
	a_sp2: assert property (p_sp2) else $error("serial 2 off");
	property p_dyn;
		STRAPS_VALID_O && PCI_EN_O && $rose(SERIAL_PORT2_SELECT_PIN_I)
			|-> ##[1:7] (SERIAL_PORT2_EN_O && !EEPROM_PATH_EN_O);
	endproperty
	a_dyn: assert property (p_dyn) else $error("serial 2 not taken over");
	property p_start;
		EEPROM_INIT_START_O |-> $rose(STRAPS_VALID_O) && PCI_EN_O && EEPROM_PATH_EN_O
			##1 !EEPROM_INIT_START_O;
	endproperty
	a_start: assert property (p_start) else $error("init start wrong");
	property p_hold;
		steady |-> $stable(CELL_PORT_EN_O) && $stable(PCI_EN_O);
	endproperty
	a_hold: assert property (p_hold) else $error("latched select moved");
	property p_on;
		STRAPS_VALID_O |-> ALWAYS_ON_EN_O;
	endproperty
	a_on: assert property (p_on) else $error("always-on off");
	c_cell: cover property ($rose(STRAPS_VALID_O) && CELL_PORT_EN_O);
	c_start: cover property (EEPROM_INIT_START_O);
	c_dyn: cover property ($rose(SERIAL_PORT2_EN_O) && PCI_EN_O);
endmodule

// ===== test/tb_top.sv
// Bench for the peripheral select block: reboots under every cell, PCI and serial-2 select mix and checks owners.
// Assumes the strap model and the checker sit beside this bench, with the design in its own directory.
`timescale 1ns/1ps
module tb_top;
	import rlps_pkg::*;
	localparam int unsigned SHARED_CELL_W = 6;
	localparam int unsigned HOST_PCI_W = 32;
	logic MCLK_I, RESET_N_I, EEPROM_INIT_DONE_I, req_cell, req_pci, req_sp2, req_eeprom_autoinit_strap;
	logic CELL_SELECT_STRAP_PIN_I, PCI_SELECT_PIN_I, SERIAL_PORT2_SELECT_PIN_I;
	logic EEPROM_AUTOINIT_STRAP_PIN_I, PCI_ONLY_PINS_OE_O, CELL_ONLY_PINS_OE_O;
	logic SP1_ONLY_PINS_OE_O, HOST_PORT_EN_O, PCI_EN_O, SERIAL_PORT1_EN_O, SERIAL_PORT2_EN_O;
	logic CELL_PORT_EN_O, EEPROM_PATH_EN_O, EEPROM_INIT_START_O, ALWAYS_ON_EN_O, STRAPS_VALID_O;
	logic [RLPS_UGP_W-1:0] GPIO_PIN_ENABLE_I, GPIO_PIN_DIRECTION_I, GPIO_OUT_I;
	logic [RLPS_UGP_W-1:0] PCI_GP_OUT_I, PCI_GP_OE_I, UPPER_GENERAL_PINS_OUT_O;
	logic [RLPS_UGP_W-1:0] UPPER_GENERAL_PINS_OE_O;
	logic [SHARED_CELL_W-1:0] SP1_OUT_I, SP1_OE_I, CELL_OUT_I, CELL_OE_I;
	logic [SHARED_CELL_W-1:0] SHARED_CELL_PINS_OUT_O, SHARED_CELL_PINS_OE_O;
	logic [HOST_PCI_W-1:0] HOST_OUT_I, HOST_OE_I, PCI_OUT_I, PCI_OE_I;
	logic [HOST_PCI_W-1:0] SHARED_HOST_PINS_OUT_O, SHARED_HOST_PINS_OE_O;
	int n_mismatch = 0;
	int num_checks = 0;
	int cycles = 0;

	rlps_top #(.SHARED_CELL_W(SHARED_CELL_W), .HOST_PCI_W(HOST_PCI_W)) u_dut (.*);
	rlps_strap_model u_straps (.reset_n_i(RESET_N_I), .cell_i(req_cell), .pci_i(req_pci),
		.sp2_i(req_sp2), .eeprom_autoinit_strap_i(req_eeprom_autoinit_strap), .cell_o(CELL_SELECT_STRAP_PIN_I),
		.pci_o(PCI_SELECT_PIN_I), .sp2_o(SERIAL_PORT2_SELECT_PIN_I),
		.eeprom_autoinit_strap_o(EEPROM_AUTOINIT_STRAP_PIN_I));

	initial begin
		MCLK_I = 1'h0;
		forever #2 MCLK_I = ~MCLK_I;
	end
	always @(posedge MCLK_I) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	//********************
	// Tasks
	//********************
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("Checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Straps change with reset asserted, then wait for the latch while catching the start pulse
	task automatic boot(input logic c, input logic p, input logic s, output logic st);
		@(posedge MCLK_I);
		RESET_N_I <= 1'h0;
		req_cell <= c;
		req_pci <= p;
		req_sp2 <= s;
		req_eeprom_autoinit_strap <= p & ~c;
		repeat (8) @(posedge MCLK_I);
		RESET_N_I <= 1'h1;
		st = 1'h0;
		for (int i = 0; i < 40 && STRAPS_VALID_O !== 1'h1; i++) begin
			@(posedge MCLK_I);
			#1;
			st |= EEPROM_INIT_START_O;
		end
	endtask
	//********************
	// Main sequence
	//********************
	initial begin
		logic c, p, s, st;
		{RESET_N_I, EEPROM_INIT_DONE_I, req_cell, req_pci, req_sp2, req_eeprom_autoinit_strap} = 6'h0;
		{GPIO_PIN_ENABLE_I, GPIO_PIN_DIRECTION_I, GPIO_OUT_I} = {7'h55, 7'h33, 7'h0F};
		{PCI_GP_OUT_I, PCI_GP_OE_I} = {7'h6A, 7'h1C};
		{SP1_OUT_I, SP1_OE_I, CELL_OUT_I, CELL_OE_I} = {6'h15, 6'h3C, 6'h2A, 6'h07};
		{HOST_OUT_I, HOST_OE_I} = {32'h1234ABCD, 32'hFFFF0000};
		{PCI_OUT_I, PCI_OE_I} = {32'hCAFE5A5A, 32'h00FF00FF};
		for (int k = 0; k < 8; k++) begin
			{s, p, c} = k[2:0];
			boot(c, p, s, st);
			check("straps_valid", STRAPS_VALID_O, 32'h1);
			check("enables", {HOST_PORT_EN_O, PCI_EN_O, SERIAL_PORT1_EN_O, SERIAL_PORT2_EN_O,
				CELL_PORT_EN_O, EEPROM_PATH_EN_O, ALWAYS_ON_EN_O},
				{!p, p, !c, !(p && !s), c, p && !s, 1'h1});
			check("only_oe", {PCI_ONLY_PINS_OE_O, CELL_ONLY_PINS_OE_O, SP1_ONLY_PINS_OE_O},
				{p, c, !c});
			check("init_start", st, p && !s && !c);
			@(posedge MCLK_I);
			GPIO_PIN_ENABLE_I <= 7'h55 ^ k[6:0];
			repeat (2) @(posedge MCLK_I);
			#1;
			check("cell_oe", SHARED_CELL_PINS_OE_O, c ? CELL_OE_I : SP1_OE_I);
			check("cell_out", SHARED_CELL_PINS_OUT_O, c ? CELL_OUT_I : SP1_OUT_I);
			check("host_oe", SHARED_HOST_PINS_OE_O, p ? PCI_OE_I : HOST_OE_I);
			check("host_out", SHARED_HOST_PINS_OUT_O, p ? PCI_OUT_I : HOST_OUT_I);
			check("gpio_oe", UPPER_GENERAL_PINS_OE_O,
				p ? PCI_GP_OE_I : GPIO_PIN_ENABLE_I & GPIO_PIN_DIRECTION_I);
			check("gpio_out", UPPER_GENERAL_PINS_OUT_O, p ? PCI_GP_OUT_I : GPIO_OUT_I);
			@(posedge MCLK_I);
			req_cell <= !c;
			repeat (9) @(posedge MCLK_I);
			check("late_cell", {CELL_PORT_EN_O, PCI_EN_O}, {c, p});
			if (p && !s) begin
				req_sp2 <= 1'h1;
				repeat (8) @(posedge MCLK_I);
				check("sp2_take", {SERIAL_PORT2_EN_O, EEPROM_PATH_EN_O}, 32'h2);
			end
			$display("Test %0d done", k);
		end
		end_of_test();
	end
endmodule

bind rlps_top rlps_top_props #(.SHARED_CELL_W(SHARED_CELL_W), .HOST_PCI_W(HOST_PCI_W)) u_props (.*);
